// *** verilog/uabd_regs.vh ***
// Purpose: Constants for the automatic rate detection block.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef UABD_REGS_VH
`define UABD_REGS_VH
`define UABD_CAL_BYTE     8'h55
`define UABD_EDGE_LAST    3'h5
`define UABD_CNT_MAX      16'hffff
`define UABD_CNT_ZERO     16'h0000
`define UABD_DIV_SEL00    10'h1ff
`define UABD_DIV_SEL01    10'h07f
`define UABD_DIV_SEL11    10'h01f
`define UABD_PRE_ZERO     10'h000
`define UABD_ST_IDLE      2'h0
`define UABD_ST_START     2'h1
`define UABD_ST_COUNT     2'h2
`define UABD_ST_BREAK     2'h3
`endif

// *** verilog/uabd_prescale.v ***
// Purpose: Counter clock tick for the rate measurement, one clock pulse.
// Assumes: Single clock domain; clr restarts the division.
// Notes: Divides by 512, 128 or 32 per the divider select bits.
`timescale 1ns/1ns
`include "uabd_regs.vh"
module uabd_prescale
(
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Control
  input  wire       run,
  input  wire       clr,
  input  wire       wide_divider_select,
  input  wire       high_speed_select,
  // Tick
  output wire       tick
);
  reg  [9:0] pre_r;
  reg  [9:0] term;

  always @*
  begin
    case ({wide_divider_select, high_speed_select})
      2'b00:   term = `UABD_DIV_SEL00;
      2'b11:   term = `UABD_DIV_SEL11;
      default: term = `UABD_DIV_SEL01;
    endcase
  end

  assign tick = run && (pre_r >= term);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pre_r <= `UABD_PRE_ZERO;
    else if (clr || !run || tick)
      pre_r <= `UABD_PRE_ZERO;
    else
      pre_r <= pre_r + 10'h001;
  end
endmodule

// *** verilog/uabd_detect.v ***
// Purpose: Automatic baud rate measurement for the asynchronous serial port.
// Assumes: 20 MHz clk; rx from a pin; control bits are plain ports.
// Notes: Software actions arrive as one-cycle strobes.
`timescale 1ns/1ns
`include "uabd_regs.vh"
module uabd_detect
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Serial line
  input  wire        rx,
  // Configuration
  input  wire        sync_mode_select,
  input  wire        wake_on_break_enable,
  input  wire        wide_divider_select,
  input  wire        high_speed_select,
  // Software strobes
  input  wire        autobaud_enable_set,
  input  wire        overflow_wr,
  input  wire        overflow_wdata,
  input  wire        divisor_low_wr,
  input  wire        divisor_high_wr,
  input  wire [7:0]  divisor_wdata,
  input  wire        receive_buffer_rd,
  // Status
  output wire        autobaud_enable,
  output wire        autobaud_overflow_flag,
  output wire [7:0]  divisor_low_byte,
  output wire [7:0]  divisor_high_byte,
  output wire        receive_ready_flag,
  output wire        rx_hold_idle,
  output wire        measuring
);
  reg        rx_s1_r;
  reg        rx_s2_r;
  reg        rx_prev_r;
  reg        en_r;
  reg        ovf_r;
  reg        rdy_r;
  reg [15:0] cnt_r;
  reg [1:0]  st_r;
  reg [2:0]  edges_r;
  reg        brk_done_r;
  wire       fall;
  wire       rise;
  wire       tick;
  wire       active;
  wire       wrap;
  wire       fifth;

  // Two stages before any logic sees the pin.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_s1_r   <= rx;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  assign fall = rx_prev_r && !rx_s2_r;
  assign rise = !rx_prev_r && rx_s2_r;

  // Synchronous mode disables detection; wake-on-break defers it to the next byte.
  assign active = en_r && !sync_mode_select;
  assign fifth  = (st_r == `UABD_ST_COUNT) && rise && (edges_r == (`UABD_EDGE_LAST - 3'h1));
  assign wrap   = (st_r == `UABD_ST_COUNT) && tick && (cnt_r == `UABD_CNT_MAX);

  uabd_prescale uabd_prescale_inst
  (
    .clk                 (clk),
    .rstn                (rstn),
    .run                 (st_r == `UABD_ST_COUNT),
    .clr                 (rise),
    .wide_divider_select (wide_divider_select),
    .high_speed_select   (high_speed_select),
    .tick                (tick)
  );

  // Sequencer.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r       <= `UABD_ST_IDLE;
      edges_r    <= 3'h0;
      brk_done_r <= 1'b0;
    end
    else if (!active)
    begin
      st_r       <= `UABD_ST_IDLE;
      edges_r    <= 3'h0;
      brk_done_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        `UABD_ST_IDLE:
        begin
          edges_r <= 3'h0;
          // The break must end before the measured byte is awaited, but only once per run.
          if (wake_on_break_enable && !brk_done_r)
            st_r <= `UABD_ST_BREAK;
          else if (fall)
            st_r <= `UABD_ST_START;
        end
        `UABD_ST_BREAK:
        begin
          if (rise)
          begin
            st_r       <= `UABD_ST_IDLE;
            brk_done_r <= 1'b1;
          end
        end
        `UABD_ST_START:
        begin
          // The bit after the start bit is the least significant one, high for the calibration byte.
          if (rise)
          begin
            st_r    <= `UABD_ST_COUNT;
            edges_r <= 3'h1;
          end
        end
        `UABD_ST_COUNT:
        begin
          if (rise)
            edges_r <= edges_r + 3'h1;
          if (fifth)
            st_r <= `UABD_ST_IDLE;
        end
        default: st_r <= `UABD_ST_IDLE;
      endcase
    end
  end

  // Divisor pair doubles as the 16-bit measurement counter.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= `UABD_CNT_ZERO;
    else if (autobaud_enable_set && !en_r)
      cnt_r <= `UABD_CNT_ZERO;
    else if (en_r)
    begin
      if (st_r == `UABD_ST_COUNT && tick)
        cnt_r <= cnt_r + 16'h0001;
    end
    else if (divisor_low_wr)
      cnt_r <= {cnt_r[15:8], divisor_wdata};
    else if (divisor_high_wr)
      cnt_r <= {divisor_wdata, cnt_r[7:0]};
  end

  // Enable bit: software sets it, the fifth edge clears it.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      en_r <= 1'b0;
    else if (fifth)
      en_r <= 1'b0;
    else if (autobaud_enable_set)
      en_r <= 1'b1;
  end

  // Hardware wrap wins over a software write in the same cycle.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ovf_r <= 1'b0;
    else if (wrap)
      ovf_r <= 1'b1;
    else if (overflow_wr)
      ovf_r <= overflow_wdata;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdy_r <= 1'b0;
    else if (fifth)
      rdy_r <= 1'b1;
    else if (receive_buffer_rd)
      rdy_r <= 1'b0;
  end

  assign autobaud_enable        = en_r;
  assign autobaud_overflow_flag = ovf_r;
  assign divisor_low_byte       = cnt_r[7:0];
  assign divisor_high_byte      = cnt_r[15:8];
  assign receive_ready_flag     = rdy_r;
  assign rx_hold_idle           = en_r;
  assign measuring              = (st_r == `UABD_ST_COUNT);
endmodule

// *** bench/uabd_tx.sv ***
// Purpose: Remote transmitter model.
// Assumes: Bit time is given in clocks.
// Notes: The line idles high.
`timescale 1ns/1ns
module uabd_tx
(
  // Line
  input  wire clk,
  output reg  rx
);
  initial rx = 1'b1;
  task send(input [7:0] b, input integer bt);
    integer i;
    rx = 1'b0;
    repeat (bt) @(negedge clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      rx = b[i];
      repeat (bt) @(negedge clk);
    end
    rx = 1'b1;
    repeat (2 * bt) @(negedge clk);
  endtask
endmodule

// *** bench/uabd_detect_sva.sv ***
// Purpose: Port checks for the rate detector.
// Assumes: Bound to uabd_detect.
// Notes: A counter wrap is too slow to reach, so only checked here.
`timescale 1ns/1ns
module uabd_detect_sva
(
  // Watched ports
  input wire       clk,
  input wire       rstn,
  input wire       sync_mode_select,
  input wire       autobaud_enable_set,
  input wire       overflow_wr,
  input wire       overflow_wdata,
  input wire       divisor_low_wr,
  input wire       divisor_high_wr,
  input wire       receive_buffer_rd,
  input wire       autobaud_enable,
  input wire       autobaud_overflow_flag,
  input wire [7:0] divisor_low_byte,
  input wire [7:0] divisor_high_byte,
  input wire       receive_ready_flag,
  input wire       rx_hold_idle,
  input wire       measuring
);
  wire [15:0] cnt = {divisor_high_byte, divisor_low_byte};
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_set_clears: assert property (autobaud_enable_set && !autobaud_enable
    |=> autobaud_enable && cnt == 16'h0000) else $error("set");
  a_done_ready: assert property ($fell(autobaud_enable)
    |-> ##[0:1] receive_ready_flag) else $error("ready");
  a_done_clear: assert property ($fell(measuring) && !$past(sync_mode_select)
    |-> ##[0:1] !autobaud_enable)
    else $error("clear");
  a_rx_hold: assert property (rx_hold_idle == autobaud_enable) else $error("hold");
  a_sync_block: assert property (sync_mode_select && !measuring |=> !measuring)
    else $error("sync");
  a_ovf_write: assert property (overflow_wr && cnt != 16'hffff
    |=> autobaud_overflow_flag == $past(overflow_wdata)) else $error("ovf");
  a_wrap_flag: assert property (measuring && cnt == 16'hffff ##1 cnt == 16'h0000
    |-> autobaud_overflow_flag && autobaud_enable) else $error("wrap");
  a_read_clear: assert property (receive_buffer_rd && !measuring
    |=> !receive_ready_flag) else $error("read");
  a_idle_stable: assert property (!measuring && !autobaud_enable_set && !divisor_low_wr
    && !divisor_high_wr |=> $stable(cnt)) else $error("stable");
  a_count_step: assert property (measuring |=> cnt - $past(cnt) <= 16'h0001)
    else $error("step");
  a_tick_gap: assert property (measuring && cnt != $past(cnt) |=> $stable(cnt) [*8])
    else $error("gap");
  cover property ($fell(autobaud_enable));
  cover property (overflow_wr && overflow_wdata);
  cover property (sync_mode_select && autobaud_enable);
endmodule

// *** bench/uabd_detect_test.sv ***
// Purpose: Self-checking bench for the rate detector.
// Assumes: Inputs change on the falling edge.
// Notes: Bit times leave half a tick of margin per edge pair.
`timescale 1ns/1ns
module uabd_detect_test;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         sync_mode_select = 1'b0;
  reg         wake_on_break_enable = 1'b0;
  reg         wide_divider_select = 1'b0;
  reg         high_speed_select = 1'b0;
  reg         overflow_wdata = 1'b0;
  reg  [7:0]  divisor_wdata = 8'h3c;
  reg  [4:0]  stb = 5'h00;
  integer     n_fail = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  wire        rx;
  wire        autobaud_enable;
  wire        autobaud_overflow_flag;
  wire        receive_ready_flag;
  wire        rx_hold_idle;
  wire        measuring;
  wire [7:0]  divisor_low_byte;
  wire [7:0]  divisor_high_byte;
  wire [15:0] cnt = {divisor_high_byte, divisor_low_byte};
  uabd_tx tx (.clk(clk), .rx(rx));
  uabd_detect uabd_detect_inst (.clk(clk), .rstn(rstn), .rx(rx),
    .sync_mode_select(sync_mode_select), .wake_on_break_enable(wake_on_break_enable),
    .wide_divider_select(wide_divider_select), .high_speed_select(high_speed_select),
    .autobaud_enable_set(stb[0]), .overflow_wr(stb[1]), .overflow_wdata(overflow_wdata),
    .divisor_low_wr(stb[2]), .divisor_high_wr(stb[4]), .divisor_wdata(divisor_wdata),
    .receive_buffer_rd(stb[3]), .autobaud_enable(autobaud_enable),
    .autobaud_overflow_flag(autobaud_overflow_flag), .divisor_low_byte(divisor_low_byte),
    .divisor_high_byte(divisor_high_byte), .receive_ready_flag(receive_ready_flag),
    .rx_hold_idle(rx_hold_idle), .measuring(measuring));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  task close_out;
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input [18:0] seen, input [18:0] want);
    n_tests = n_tests + 1;
    if (seen !== want)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task pulse(input [4:0] s);
    stb = s;
    @(negedge clk);
    stb = 5'h00;
    @(negedge clk);
  endtask
  task cal(input [1:0] sel, input integer bt, input [15:0] want, input wk);
    {wide_divider_select, high_speed_select} = sel;
    wake_on_break_enable = wk;
    pulse(5'h01);
    chk(cnt, 16'h0000);
    chk(rx_hold_idle, 1'b1);
    if (wk)
      tx.send(8'h00, bt);
    tx.send(8'h55, bt);
    chk(cnt, want);
    chk(autobaud_enable, 1'b0);
    chk(measuring, 1'b0);
    chk(rx_hold_idle, 1'b0);
    chk(receive_ready_flag, 1'b1);
    pulse(5'h08);
    chk(receive_ready_flag, 1'b0);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk({autobaud_enable, autobaud_overflow_flag, receive_ready_flag, cnt}, 19'h00000);
    pulse(5'h04);
    chk(cnt, 16'h003c);
    pulse(5'h10);
    chk(cnt, 16'h3c3c);
    overflow_wdata = 1'b1;
    pulse(5'h02);
    chk(autobaud_overflow_flag, 1'b1);
    overflow_wdata = 1'b0;
    pulse(5'h02);
    chk(autobaud_overflow_flag, 1'b0);
    sync_mode_select = 1'b1;
    pulse(5'h01);
    pulse(5'h04);
    chk(cnt, 16'h0000);
    tx.send(8'h55, 88);
    chk({autobaud_enable, cnt}, 17'h10000);
    sync_mode_select = 1'b0;
    cal(2'h0, 640, 16'h0008, 1'b0);
    cal(2'h1, 224, 16'h000c, 1'b0);
    cal(2'h2, 224, 16'h000c, 1'b0);
    cal(2'h3, 88, 16'h0014, 1'b1);
    close_out;
  end
endmodule
bind uabd_detect uabd_detect_sva uabd_detect_sva_inst (.clk, .rstn, .sync_mode_select,
  .autobaud_enable_set, .overflow_wr, .overflow_wdata, .divisor_low_wr, .divisor_high_wr,
  .receive_buffer_rd, .autobaud_enable, .autobaud_overflow_flag, .divisor_low_byte,
  .divisor_high_byte, .receive_ready_flag, .rx_hold_idle, .measuring);
